// *** logic/ornt_pkg.sv ***
/*
 orientation detect configuration: register offsets, reset values,
 field positions, angle constants and the orientation struct.
 assumes nothing; included via import by every orientation file but the host model.
*/
package ornt_pkg;
	// register offsets on the device register port
	localparam logic [7:0] ORNT_ADDR_RESULT = 8'h28;
	localparam logic [7:0] ORNT_ADDR_CTRL   = 8'h29;
	localparam logic [7:0] ORNT_ADDR_DBLEN  = 8'h2a;
	localparam logic [7:0] ORNT_ADDR_COMP   = 8'h2b;
	// values after reset
	localparam logic [7:0] ORNT_CTRL_RST    = 8'h80;
	localparam logic [7:0] ORNT_DBLEN_RST   = 8'h00;
	localparam logic [7:0] ORNT_COMP_RST    = 8'h44;
	// field positions
	localparam int ORNT_MODE_BIT = 7;   // mismatch action
	localparam int ORNT_EN_BIT   = 6;   // function on
	localparam int ORNT_BF_LSB   = 6;   // trip select, 2 bits
	localparam int ORNT_ZL_LSB   = 0;   // lockout select, 3 bits
	localparam int ORNT_FLAG_BIT = 7;   // result: changed flag
	localparam int ORNT_LO_BIT   = 6;   // result: lockout
	localparam int ORNT_LP_LSB   = 1;   // result: landscape/portrait
	localparam int ORNT_BF_BIT   = 0;   // result: back/front
	// back/front window edges in whole degrees
	localparam logic [8:0] ORNT_B2F_BASE  = 9'h050;  // 80
	localparam logic [8:0] ORNT_F2B_BASE  = 9'h064;  // 100
	localparam logic [8:0] ORNT_FULL_TURN = 9'h168;  // 360
	// lockout thresholds in tenths of a degree, per select code
	localparam logic [9:0] ORNT_ZLOCK_TBL [8] = '{
		10'h088, 10'h0ab, 10'h0cf, 10'h0f4,
		10'h119, 10'h140, 10'h169, 10'h194};
	// one orientation sample
	typedef struct packed {
		logic       lo;   // tilt lockout
		logic [1:0] lp;   // landscape/portrait
		logic       bf;   // 1 back, 0 front
	} ornt_orient_s;
endpackage

// *** logic/ornt_dbnc_if.sv ***
/*
 orientation detect: carrier between the configuration top and the
 debounce engine. assumes both ends run on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
interface ornt_dbnc_if;
	import ornt_pkg::*;
	logic         tick;        // one sample period elapsed
	logic         restart;     // power transition, counter to zero
	logic         clear_state; // standby to active, state to zero
	logic         freeze;      // acceleration above 1.25 g
	logic         mode_clear;  // mismatch clears, else decrements
	logic [7:0]   len;         // debounce length in samples
	ornt_orient_s cand;        // this sample's orientation
	logic         accept;      // candidate accepted this cycle
	ornt_orient_s state;       // accepted orientation
	modport top  (output tick, restart, clear_state, freeze,
		mode_clear, len, cand, input accept, state);
	modport dbnc (input tick, restart, clear_state, freeze,
		mode_clear, len, cand, output accept, state);
endinterface
`default_nettype wire

// *** logic/ornt_debounce.sv ***
/*
 orientation debounce engine: counts samples a new orientation holds
 and accepts it after the programmed length.
 assumes tick only pulses while the function is on and active.
*/
`timescale 1ns/100ps
`default_nettype none
module ornt_debounce (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	ornt_dbnc_if.dbnc bus
);
	import ornt_pkg::*;

	logic [7:0]   cnt_q;     // debounce counter
	logic [7:0]   cnt_n;     // counter after this sample
	ornt_orient_s prev_q;    // previous sample
	ornt_orient_s state_q;   // accepted orientation
	logic         first_q;   // first detection pending
	wire  logic   mismatch;  // sample differs from previous
	wire  logic   differs;   // sample differs from accepted
	wire  logic   step;      // sample taken this cycle
	wire  logic [7:0] cnt_up;
	wire  logic [7:0] cnt_dn;

	assign step     = bus.tick & ~bus.freeze & ~bus.restart;
	assign mismatch = bus.cand != prev_q;
	assign differs  = bus.cand != state_q;
	// saturating up and down steps
	assign cnt_up = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
	assign cnt_dn = (cnt_q == 8'h00) ? cnt_q : cnt_q - 8'h01;
	// mismatch either clears or decrements
	assign cnt_n = !mismatch ? cnt_up :
		(bus.mode_clear ? 8'h00 : cnt_dn);
	// accept after len samples; zero length on first sight
	assign bus.accept = step & (first_q | (differs & (mismatch ?
		(bus.len == 8'h00) : (cnt_n >= bus.len))));
	assign bus.state = state_q;

	// counter, history and accepted state
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q   <= 8'h00;
			prev_q  <= '0;
			state_q <= '0;
			first_q <= 1'b1;
		end else if (bus.restart) begin
			cnt_q <= 8'h00;
			if (bus.clear_state) begin
				state_q <= '0;
				first_q <= 1'b1;
			end
		end else if (step) begin
			// one advance per sample period
			prev_q <= bus.cand;
			cnt_q  <= bus.accept ? 8'h00 : cnt_n;
			if (bus.accept) begin
				state_q <= bus.cand;
				first_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_freeze_holds: assert property (
		bus.tick && bus.freeze && !bus.restart |=> $stable(cnt_q))
		else $error("counter moved while frozen");
	a_restart_zero: assert property (
		bus.restart |=> cnt_q == 8'h00)
		else $error("counter not reset on power transition");
	a_mis_clear: assert property (
		step && mismatch && bus.mode_clear |=> cnt_q == 8'h00)
		else $error("mismatch did not clear counter");
	a_mis_dec: assert property (
		step && mismatch && !bus.mode_clear && cnt_q != 8'h00
		&& !bus.accept |=> cnt_q == $past(cnt_q) - 8'h01)
		else $error("mismatch did not decrement counter");
	a_len_zero_now: assert property (
		step && differs && bus.len == 8'h00 |-> bus.accept)
		else $error("zero length did not accept at once");
	a_len_honoured: assert property (
		bus.accept && !first_q && bus.len != 8'h00
		|-> !mismatch && cnt_q >= bus.len - 8'h01)
		else $error("accepted before debounce length");
	c_accept_long: cover property (
		step && !mismatch && bus.len > 8'h02 && bus.accept);
	c_freeze_hit: cover property (bus.tick && bus.freeze);
endmodule
`default_nettype wire

// *** logic/ornt_cfg.sv ***
/*
 orientation detect configuration top: control, debounce length and
 angle compensation registers, result register with changed flag,
 candidate orientation decode and the debounce engine.
 assumes every input comes from logic on clk_sys; the register port
 is the device's internal register access, one request per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module ornt_cfg (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	input  wire logic       active_mode,
	input  wire logic       wake_mode,
	input  wire logic       flex_mode,
	input  wire logic       sample_tick,
	input  wire logic       flex_sample_tick,
	input  wire logic       over_range,
	input  wire logic [8:0] z_angle_deg,
	input  wire logic [9:0] tilt_angle_ddeg,
	input  wire logic [1:0] lp_sample,
	output logic            orientation_changed_flag
);
	import ornt_pkg::*;

	ornt_dbnc_if dbus ();  // carrier to the debounce engine

	logic [7:0] ctrl_q;      // orientation_control
	logic [7:0] dblen_q;     // orientation_debounce_length
	logic [7:0] comp_q;      // orientation_angle_compensation
	logic       flag_q;      // orientation_changed_flag
	logic [7:0] rdata_q;     // read data register
	logic       active_q;    // last active/standby level
	logic       wake_q;      // last wake/sleep level

	// register decode
	wire logic hit_ctrl   = reg_addr == ORNT_ADDR_CTRL;
	wire logic hit_dblen  = reg_addr == ORNT_ADDR_DBLEN;
	wire logic hit_comp   = reg_addr == ORNT_ADDR_COMP;
	wire logic hit_result = reg_addr == ORNT_ADDR_RESULT;
	wire logic rd_result  = reg_rd & hit_result;

	// control and compensation fields
	wire logic       func_on  = ctrl_q[ORNT_EN_BIT];
	wire logic       mis_clr  = ctrl_q[ORNT_MODE_BIT];
	wire logic [1:0] bf_sel   = comp_q[ORNT_BF_LSB +: 2];
	wire logic [2:0] zl_sel   = comp_q[ORNT_ZL_LSB +: 3];

	// power transitions
	wire logic act_edge  = active_mode ^ active_q;
	wire logic wake_edge = wake_mode ^ wake_q;
	wire logic to_active = active_mode & ~active_q;

	// sample period source by operating mode
	wire logic tick_src = flex_mode ? flex_sample_tick
		: sample_tick;

	// back/front edges: five degrees per code step
	wire logic [8:0] bf_step = {5'h00, bf_sel, 2'b00}
		+ {7'h00, bf_sel};
	wire logic [8:0] b2f_edge = ORNT_B2F_BASE - bf_step;
	wire logic [8:0] f2b_edge = ORNT_F2B_BASE + bf_step;
	wire logic to_front = (z_angle_deg < b2f_edge)
		|| (z_angle_deg > ORNT_FULL_TURN - b2f_edge);
	wire logic to_back = (z_angle_deg > f2b_edge)
		&& (z_angle_deg < ORNT_FULL_TURN - f2b_edge);
	// between the windows the last back/front holds
	wire logic bf_cand = to_front ? 1'b0
		: (to_back ? 1'b1 : dbus.state.bf);

	// lockout below the selected tilt
	wire logic [9:0] zl_thr  = ORNT_ZLOCK_TBL[zl_sel];
	wire logic       lo_cand = tilt_angle_ddeg < zl_thr;

	// result register image
	wire logic [7:0] result_img = {flag_q, dbus.state.lo, 3'b000,
		dbus.state.lp, dbus.state.bf};

	// read mux; unmapped offsets read zero
	wire logic [7:0] rd_mux = hit_ctrl ? ctrl_q
		: hit_dblen ? dblen_q
		: hit_comp ? comp_q
		: hit_result ? result_img : 8'h00;

	// drive the debounce engine
	assign dbus.tick        = tick_src & func_on & active_mode;
	assign dbus.restart     = act_edge | wake_edge;
	assign dbus.clear_state = to_active;
	assign dbus.freeze      = over_range;
	assign dbus.mode_clear  = mis_clr;
	assign dbus.len         = dblen_q;
	assign dbus.cand        = '{lo: lo_cand, lp: lp_sample,
		bf: bf_cand};

	ornt_debounce u_dbnc (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.bus     (dbus)
	);

	// writable registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q  <= ORNT_CTRL_RST;
			dblen_q <= ORNT_DBLEN_RST;
			comp_q  <= ORNT_COMP_RST;
		end else if (reg_wr) begin
			if (hit_ctrl)
				ctrl_q <= reg_wdata;
			if (hit_dblen)
				dblen_q <= reg_wdata;
			if (hit_comp)
				comp_q <= reg_wdata;
		end
	end

	// changed flag: a new acceptance wins over a read clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			flag_q <= 1'b0;
		else if (dbus.accept)
			flag_q <= 1'b1;
		else if (rd_result)
			flag_q <= 1'b0;
	end

	// read data and power level history
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_q  <= 8'h00;
			active_q <= 1'b0;
			wake_q   <= 1'b0;
		end else begin
			if (reg_rd)
				rdata_q <= rd_mux;
			active_q <= active_mode;
			wake_q   <= wake_mode;
		end
	end

	assign reg_rdata                = rdata_q;
	assign orientation_changed_flag = flag_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// enable gating, tick source and flag handling
	a_enable_gates: assert property (
		!func_on |-> !dbus.tick && !dbus.accept)
		else $error("engine ticked while function off");
	a_flag_sets: assert property (
		dbus.accept |=> flag_q ##1 (flag_q || $past(rd_result)))
		else $error("flag not set on orientation change");
	a_read_clears: assert property (
		rd_result && !dbus.accept |=> !flag_q)
		else $error("result read did not clear flag");
	a_read_sees_flag: assert property (
		rd_result && flag_q |=> reg_rdata[ORNT_FLAG_BIT])
		else $error("read lost the pending flag");
	a_tick_source: assert property (
		dbus.tick |-> (flex_mode ? flex_sample_tick : sample_tick))
		else $error("tick from wrong sample source");
	// back/front windows at fixed angle points
	a_front_window: assert property (
		bf_sel == 2'b00 && z_angle_deg < 9'h050 |-> !bf_cand)
		else $error("front window wrong for code zero");
	// 115 sits between the code three windows: last state holds
	a_back_window: assert property (
		bf_sel == 2'b11 && z_angle_deg == 9'h073 |-> bf_cand
		== dbus.state.bf)
		else $error("back window not narrowed by code");
	a_power_restart: assert property (
		wake_mode != wake_q || active_mode != active_q
		|-> dbus.restart)
		else $error("power change did not restart counter");
	// writes land in the addressed register
	a_write_lands: assert property (
		reg_wr && hit_comp |=> comp_q == $past(reg_wdata))
		else $error("compensation write did not land");
	// no sample period in standby, no acceptance above 1.25 g
	a_standby_idle: assert property (
		!active_mode |-> !dbus.tick)
		else $error("engine ticked in standby");
	a_freeze_locks: assert property (
		over_range |-> !dbus.accept)
		else $error("orientation changed above 1.25 g");
	// standby to active forgets the accepted orientation
	a_state_cleared: assert property (
		to_active |=> dbus.state == 4'h0)
		else $error("state kept across standby to active");
	// fixed angle points against the stated windows
	a_lock_default: assert property (
		zl_sel == 3'h4 && tilt_angle_ddeg < 10'h119 |-> lo_cand)
		else $error("no lockout below 28.1 degrees");
	a_back_code0: assert property (
		bf_sel == 2'b00 && z_angle_deg > 9'h064
		&& z_angle_deg < 9'h104 |-> bf_cand)
		else $error("back window wrong for code zero");

	// main scenarios
	c_flag_read: cover property (flag_q ##[1:20] rd_result);
	c_set_on_clear: cover property (dbus.accept && rd_result);
	c_wake_change: cover property (wake_edge && func_on);
endmodule
`default_nettype wire

// *** test/ornt_host.sv ***
/*
 host model: register reads and writes on the device register port.
 assumes calls start at a falling edge of clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module ornt_host (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_wdata
);
	// idle at time zero: no strobe
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
	end
	// one strobe cycle, then lines scrambled so nothing stale lingers
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_sys);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge clk_sys);
		q = reg_rdata;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// *** test/orientation_detect_config_test.sv ***
/*
 self-checking bench for the orientation configuration top.
 assumes ornt_pkg, the carrier, the design and ornt_host compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module orientation_detect_config_test;
	import ornt_pkg::*;
	logic       clk_sys = 1'b0;          // 10 MHz
	logic       reset_n = 1'b0;          // sync, active low
	logic       active_mode = 1'b1;      // active
	logic       wake_mode = 1'b0;        // auto sleep state
	logic       flex_mode = 1'b0;        // tick source select
	logic       sample_tick = 1'b0;      // normal sample period
	logic       flex_sample_tick = 1'b0; // flexible sample period
	logic       over_range = 1'b0;       // above 1.25 g
	logic [8:0] z_angle_deg = 9'h000;    // front
	logic [9:0] tilt_angle_ddeg = 10'h384; // no lockout
	logic [1:0] lp_sample = 2'h0;        // portrait up
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic       reg_wr, reg_rd, orientation_changed_flag;
	int         bad_count = 0;           // mismatches
	int         checked = 0;             // comparisons
	// lockout thresholds in tenths of a degree
	logic [9:0] lk [8] = '{10'h088, 10'h0ab, 10'h0cf, 10'h0f4,
		10'h119, 10'h140, 10'h169, 10'h194};
	always #50 clk_sys = ~clk_sys;
	ornt_cfg dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.active_mode(active_mode), .wake_mode(wake_mode),
		.flex_mode(flex_mode), .sample_tick(sample_tick),
		.flex_sample_tick(flex_sample_tick), .over_range(over_range),
		.z_angle_deg(z_angle_deg), .tilt_angle_ddeg(tilt_angle_ddeg),
		.lp_sample(lp_sample),
		.orientation_changed_flag(orientation_changed_flag));
	ornt_host host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));
	// compare and count
	task automatic chk(input string n, input logic [7:0] e, s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		host_u.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.acc(1'b0, a, 8'h00, q);
	endtask
	// one sample period on the selected source, then settle
	task automatic tick(input logic [1:0] v);
		@(negedge clk_sys);
		lp_sample = v;
		sample_tick = !flex_mode;
		flex_sample_tick = flex_mode;
		@(negedge clk_sys);
		{sample_tick, flex_sample_tick} = 2'b00;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic flag(input logic e);
		chk("flag", {7'h0, e}, {7'h0, orientation_changed_flag});
	endtask
	// n samples of v: only the last one may raise the flag
	task automatic hold(input logic [1:0] v, input int n);
		for (int i = 1; i <= n; i++) begin
			tick(v);
			flag(i == n);
		end
		rd(ORNT_ADDR_RESULT);
		chk("result", {1'b1, 4'h0, v, 1'b0}, q);
		flag(1'b0);
	endtask
	// one sample at given angles, result lockout and back bits
	task automatic ang(input logic [8:0] z, input logic [9:0] t,
		input logic [1:0] e);
		z_angle_deg = z;
		tilt_angle_ddeg = t;
		tick(2'h1);
		rd(ORNT_ADDR_RESULT);
		chk("lo bf", {6'h0, e}, {6'h0, q[6], q[0]});
	endtask
	task automatic t_regs;
		rd(ORNT_ADDR_CTRL);
		chk("ctrl", 8'h80, q);
		rd(ORNT_ADDR_DBLEN);
		chk("length", 8'h00, q);
		rd(ORNT_ADDR_COMP);
		chk("comp", 8'h44, q);
		wr(ORNT_ADDR_RESULT, 8'hff);
		rd(ORNT_ADDR_RESULT);
		chk("result", 8'h00, q);
		rd(8'h30);
		chk("unmapped", 8'h00, q);
	endtask
	task automatic t_seq;
		tick(2'h1);
		tick(2'h2);
		flag(1'b0);
		wr(ORNT_ADDR_CTRL, 8'hc0);
		hold(2'h0, 1);
		wr(ORNT_ADDR_DBLEN, 8'h02);
		hold(2'h1, 3);
		wr(ORNT_ADDR_DBLEN, 8'h00);
		flex_mode = 1'b1;
		lp_sample = 2'h2;
		sample_tick = 1'b1;
		@(negedge clk_sys);
		sample_tick = 1'b0;
		repeat (2) @(negedge clk_sys);
		flag(1'b0);
		hold(2'h2, 1);
		flex_mode = 1'b0;
	endtask
	task automatic t_count;
		wr(ORNT_ADDR_DBLEN, 8'h02);
		tick(2'h3);
		over_range = 1'b1;
		repeat (3) tick(2'h3);
		flag(1'b0);
		over_range = 1'b0;
		hold(2'h3, 2);
		tick(2'h0);
		tick(2'h0);
		wake_mode = 1'b1;
		@(negedge clk_sys);
		hold(2'h0, 2);
		active_mode = 1'b0;
		@(negedge clk_sys);
		active_mode = 1'b1;
		@(negedge clk_sys);
		hold(2'h0, 1);
		wr(ORNT_ADDR_DBLEN, 8'h03);
		wr(ORNT_ADDR_CTRL, 8'h40);
		repeat (3) tick(2'h1);
		hold(2'h2, 3);
		wr(ORNT_ADDR_CTRL, 8'hc0);
		repeat (3) tick(2'h0);
		hold(2'h1, 4);
	endtask
	task automatic t_angle;
		logic [8:0] s;
		wr(ORNT_ADDR_DBLEN, 8'h00);
		for (int c = 0; c < 4; c++) begin
			s = 9'(5 * c);
			wr(ORNT_ADDR_COMP, {c[1:0], 6'h04});
			ang(9'h000, 10'h384, 2'b00);
			ang(9'h064 + s, 10'h384, 2'b00);
			ang(9'h065 + s, 10'h384, 2'b01);
			ang(9'h118 + s, 10'h384, 2'b01);
			ang(9'h119 + s, 10'h384, 2'b00);
		end
		foreach (lk[c]) begin
			wr(ORNT_ADDR_COMP, {5'h08, c[2:0]});
			ang(9'h000, lk[c] - 10'h001, 2'b10);
			ang(9'h000, lk[c], 2'b00);
		end
	endtask
	// verdict and end of run
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk_sys);
		reset_n = 1'b1;
		t_regs;
		$display("test regs done");
		t_seq;
		$display("test enable and length done");
		t_count;
		$display("test counter done");
		t_angle;
		$display("test angles done");
		finish_test;
	end
	// watchdog: the run needs a few hundred cycles at most
	initial begin
		#2000000;
		bad_count++;
		finish_test;
	end
endmodule
`default_nettype wire
